// ### rtl/pfar_pkg.sv
package pfar_pkg;

	// clock rate in kHz, used to turn times into cycle counts
	localparam int unsigned CLK_KHZ = 250000;

	// timer lengths as printed, in ms
	localparam int unsigned INIT_PUP_MS = 150;
	localparam int unsigned INIT_RST_MS = 100;
	localparam int unsigned WINDOW_MS = 2;
	localparam int unsigned POWERDOWN_TIMER_MS = 2;

	// derived cycle counts
	localparam int unsigned INIT_PUP_CYC = INIT_PUP_MS * CLK_KHZ;
	localparam int unsigned INIT_RST_CYC = INIT_RST_MS * CLK_KHZ;
	localparam int unsigned WINDOW_CYC = WINDOW_MS * CLK_KHZ;
	localparam int unsigned POWERDOWN_TIMER_CYC = POWERDOWN_TIMER_MS * CLK_KHZ;

	// counter width, big enough for the longest count
	localparam int unsigned CNT_W = 26;

	// power-up microroutine entry address and vector locations (octal 24 and 26)
	localparam logic [8:0] PUP_UADDR = 9'h001;
	localparam logic [15:0] PWR_PC_VEC = 16'h0014;
	localparam logic [15:0] PWR_PSW_VEC = 16'h0016;

	// values after reset
	localparam logic POWER_INIT_RST = 1'b0;

	// sequencer states
	typedef enum logic [4:0] {
		PF_OFF = 5'b00001,
		PF_INIT = 5'b00010,
		PF_WINDOW = 5'b00100,
		PF_RUN = 5'b01000,
		PF_POWERDOWN_TIMER = 5'b10000
	} pfar_state_e;

	// request toward the microprogram sequencer
	typedef struct packed {
		logic power_init;
		logic [8:0] uaddr;
		logic [15:0] pc_vec;
		logic [15:0] psw_vec;
		logic halt_after;
	} pfar_ucode_s;

endpackage

// ### rtl/pfar_timer.sv
`timescale 1ns/100ps

// retriggerable one-shot counting a loaded number of cycles
module pfar_timer
	import pfar_pkg::*;
#(
	parameter int unsigned W = CNT_W
)
(
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic [W-1:0] len_i,
	input wire logic stop_i,
	output logic busy_o,
	output logic done_o
);

	logic [W-1:0] cnt_q;

	// refuse a counter too narrow to count down
	if (W < 2)
	begin : g_w_check
		$error("pfar_timer: width too small");
	end

	// count down, a start reloads even when running
	always_ff @(posedge mclk_i)
	begin
		if (srst_i || stop_i)
		begin
			cnt_q <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end
		else if (start_i)
		begin
			cnt_q <= len_i - W'(1);
			busy_o <= 1'b1;
			done_o <= 1'b0;
		end
		else if (busy_o)
		begin
			cnt_q <= cnt_q - W'(1);
			busy_o <= (cnt_q != '0);
			done_o <= (cnt_q == '0); // one-cycle end pulse
		end
		else
			done_o <= 1'b0;
	end

endmodule // pfar_timer

// ### rtl/pfar_seq.sv
`timescale 1ns/100ps

// Function
// - dc-low release starts 150 ms initialise
// - init end, dc high, not after reset instr: window, vector load
// - 2 ms window masks ac-low warning
// - init trigger sets power init flag, not on reset instr
// - restore loads pc 24, psw 26
// - halt request: still fetch vectors, halt
// - ac-low after window fires power-down timer
// - pending flag latched at service state
// - trap pushes pc, psw; loads vectors
// - no dc-low: power-down expiry restarts init
// - reset instruction gives 100 ms initialise
module pfar_seq
	import pfar_pkg::*;
#(
	parameter int unsigned INIT_PUP_CNT = INIT_PUP_CYC,
	parameter int unsigned INIT_RST_CNT = INIT_RST_CYC,
	parameter int unsigned WINDOW_CNT = WINDOW_CYC,
	parameter int unsigned POWERDOWN_TIMER_CNT = POWERDOWN_TIMER_CYC
)
(
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic ac_low_warning_n_i,
	input wire logic dc_low_shutdown_n_i,
	input wire logic halt_request_i,
	input wire logic reset_instr_i,
	input wire logic service_state_i,
	input wire logic trap_taken_i,
	input wire logic pup_done_i,
	output logic init_o,
	output logic powerup_window_o,
	output logic power_fail_pending_o,
	output logic power_fail_trap_o,
	output logic powerup_start_o,
	output logic halt_o,
	output pfar_ucode_s ucode_o
);

	pfar_state_e state_q;
	logic [1:0] ac_sync_q;
	logic [1:0] dc_sync_q;
	logic ac_low;
	logic dc_low;
	logic pfail_raw_q;
	logic rst_req_q;
	logic rst_init_q;
	logic halt_arm_q;
	logic init_start;
	logic init_busy;
	logic init_done;
	logic win_start;
	logic win_busy;
	logic win_done;
	logic pd_start;
	logic pd_busy;
	logic pd_done;
	logic [CNT_W-1:0] init_len;

	// refuse counts the timers cannot serve
	if (INIT_PUP_CNT < 2 || INIT_RST_CNT < 2 || WINDOW_CNT < 2 || POWERDOWN_TIMER_CNT < 2)
	begin : g_cnt_min
		$error("pfar_seq: counts must be at least 2");
	end
	if (INIT_PUP_CNT >= (1 << CNT_W) || INIT_RST_CNT >= (1 << CNT_W)
		|| WINDOW_CNT >= (1 << CNT_W) || POWERDOWN_TIMER_CNT >= (1 << CNT_W))
	begin : g_cnt_max
		$error("pfar_seq: count exceeds counter width");
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			ac_sync_q <= 2'h0;
			dc_sync_q <= 2'h3;
		end
		else
		begin
			ac_sync_q <= {ac_sync_q[0], ~ac_low_warning_n_i};
			dc_sync_q <= {dc_sync_q[0], ~dc_low_shutdown_n_i};
		end
	end

	assign ac_low = ac_sync_q[1];
	assign dc_low = dc_sync_q[1];

	// power-up init trigger, also power-down restart
	assign init_start = (state_q == PF_OFF && !dc_low) || (state_q == PF_POWERDOWN_TIMER && pd_done && !dc_low)
		|| (rst_req_q && state_q == PF_RUN);
	assign init_len = (rst_req_q && state_q == PF_RUN) ? CNT_W'(INIT_RST_CNT) : CNT_W'(INIT_PUP_CNT);
	assign win_start = state_q == PF_INIT && init_done && !rst_init_q && !dc_low;
	assign pd_start = state_q == PF_RUN && ac_low && !rst_req_q;

	pfar_timer #(.W(CNT_W)) u_init (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.start_i(init_start),
		.len_i(init_len),
		.stop_i(1'b0),
		.busy_o(init_busy),
		.done_o(init_done)
	);

	pfar_timer #(.W(CNT_W)) u_window (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.start_i(win_start),
		.len_i(CNT_W'(WINDOW_CNT)),
		.stop_i(dc_low),
		.busy_o(win_busy),
		.done_o(win_done)
	);

	pfar_timer #(.W(CNT_W)) u_powerdown_timer (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.start_i(pd_start),
		.len_i(CNT_W'(POWERDOWN_TIMER_CNT)),
		.stop_i(dc_low),
		.busy_o(pd_busy),
		.done_o(pd_done)
	);

	// sequencer states
	always_ff @(posedge mclk_i)
	begin
		if (srst_i || dc_low)
			state_q <= PF_OFF;
		else
		begin
			unique case (state_q)
				PF_OFF:
					if (init_start)
						state_q <= PF_INIT;
				PF_INIT:
					if (init_done)
						state_q <= rst_init_q ? PF_RUN : PF_WINDOW;
				PF_WINDOW:
					if (win_done)
						state_q <= PF_RUN;
				PF_RUN:
					if (init_start)
						state_q <= PF_INIT;
					else if (pd_start)
						state_q <= PF_POWERDOWN_TIMER;
				PF_POWERDOWN_TIMER:
					if (pd_done)
						state_q <= PF_INIT;
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			rst_req_q <= 1'b0;
			rst_init_q <= 1'b0;
		end
		else
		begin
			rst_req_q <= reset_instr_i && state_q == PF_RUN && !rst_req_q;
			if (init_start)
				rst_init_q <= rst_req_q && state_q == PF_RUN;
		end
	end

	// pending warning, latched at service state
	always_ff @(posedge mclk_i)
	begin
		if (srst_i || dc_low)
		begin
			pfail_raw_q <= 1'b0;
			power_fail_pending_o <= 1'b0;
			power_fail_trap_o <= 1'b0;
		end
		else
		begin
			// a new warning wins over the trap-taken clear
			if (pd_start)
				pfail_raw_q <= 1'b1;
			else if (trap_taken_i || (state_q != PF_POWERDOWN_TIMER && state_q != PF_RUN))
				pfail_raw_q <= 1'b0;
			if (service_state_i)
				power_fail_pending_o <= pd_start || (pfail_raw_q && !trap_taken_i);
			// trap request until microcode takes it
			if (service_state_i && (pd_start || (pfail_raw_q && !trap_taken_i)))
				power_fail_trap_o <= 1'b1;
			else if (trap_taken_i)
				power_fail_trap_o <= 1'b0;
		end
	end

	// power init flag and vector request
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			ucode_o <= '{POWER_INIT_RST, 9'h000, 16'h0000, 16'h0000, 1'b0};
			powerup_start_o <= 1'b0;
		end
		else
		begin
			if (init_start && !(rst_req_q && state_q == PF_RUN))
				ucode_o.power_init <= 1'b1;
			else if (pup_done_i)
				ucode_o.power_init <= 1'b0;
			ucode_o.uaddr <= PUP_UADDR;
			ucode_o.pc_vec <= PWR_PC_VEC;
			ucode_o.psw_vec <= PWR_PSW_VEC;
			ucode_o.halt_after <= halt_request_i;
			powerup_start_o <= win_start;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i || dc_low)
		begin
			halt_arm_q <= 1'b0;
			halt_o <= 1'b0;
		end
		else
		begin
			if (win_start)
				halt_arm_q <= halt_request_i;
			else if (pup_done_i)
				halt_arm_q <= 1'b0;
			halt_o <= (pup_done_i && (halt_arm_q || halt_request_i)) || (halt_o && halt_request_i);
		end
	end

	// status outputs
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			init_o <= 1'b0;
			powerup_window_o <= 1'b0;
		end
		else
		begin
			init_o <= init_busy || init_start;
			powerup_window_o <= win_busy || win_start;
		end
	end

endmodule // pfar_seq

// ### verification/pfar_supply.sv
`timescale 1ns/100ps

// supply model: shutdown clears before warning on power-up
module pfar_supply #(
	parameter int GAP = 8
)
(
	input wire logic mclk_i,
	input wire logic mains_i,
	input wire logic brief_i,
	output logic ac_low_warning_n_o,
	output logic dc_low_shutdown_n_o
);
	int lvl_q = 0;

	// stored energy rises with mains and drains without it
	always_ff @(posedge mclk_i)
	begin
		if (mains_i && lvl_q < GAP)
			lvl_q <= lvl_q + 1;
		else if (!mains_i && lvl_q > 0)
			lvl_q <= lvl_q - 1;
	end

	// warning drops first, shutdown only once energy is gone
	assign ac_low_warning_n_o = lvl_q == GAP && !brief_i;
	assign dc_low_shutdown_n_o = lvl_q > 0;
endmodule // pfar_supply

// ### verification/pfar_seq_sva.sv
`timescale 1ns/100ps

module pfar_seq_sva
	import pfar_pkg::*;
(
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic dc_low_shutdown_n_i,
	input wire logic halt_request_i,
	input wire logic service_state_i,
	input wire logic trap_taken_i,
	input wire logic init_o,
	input wire logic powerup_window_o,
	input wire logic power_fail_pending_o,
	input wire logic power_fail_trap_o,
	input wire logic powerup_start_o,
	input wire logic halt_o,
	input wire pfar_ucode_s ucode_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	init_min_a: assert property ($rose(init_o) |-> init_o [*8])
		else $error("init pulse too short");
	win_follow_a: assert property ($rose(powerup_window_o) |-> $past(init_o, 2) || $past(init_o))
		else $error("window without init");
	start_pulse_a: assert property (powerup_start_o |=> !powerup_start_o)
		else $error("start not a pulse");
	win_mask_a: assert property (powerup_window_o |-> !$rose(power_fail_pending_o))
		else $error("warning seen in window");
	uaddr_ok_a: assert property (ucode_o.power_init |-> ucode_o.uaddr == PUP_UADDR)
		else $error("bad micro address");
	vector_ok_a: assert property ((powerup_start_o || power_fail_trap_o) |->
		ucode_o.pc_vec == PWR_PC_VEC && ucode_o.psw_vec == PWR_PSW_VEC)
		else $error("bad vectors");
	halt_src_a: assert property ($rose(halt_o) |-> $past(halt_request_i))
		else $error("halt without request");
	pend_svc_a: assert property ($rose(power_fail_pending_o) |-> $past(service_state_i))
		else $error("pending outside service");
	trap_hold_a: assert property (power_fail_trap_o && !trap_taken_i && $past(dc_low_shutdown_n_i, 2)
		|=> power_fail_trap_o || init_o)
		else $error("trap dropped early");
	dc_off_a: assert property (!dc_low_shutdown_n_i [*5] |-> !init_o && !powerup_window_o)
		else $error("active in shutdown");
endmodule // pfar_seq_sva

bind pfar_seq pfar_seq_sva u_sva (.mclk_i(mclk_i), .srst_i(srst_i),
	.dc_low_shutdown_n_i(dc_low_shutdown_n_i), .halt_request_i(halt_request_i),
	.service_state_i(service_state_i), .trap_taken_i(trap_taken_i), .init_o(init_o),
	.powerup_window_o(powerup_window_o), .power_fail_pending_o(power_fail_pending_o),
	.power_fail_trap_o(power_fail_trap_o), .powerup_start_o(powerup_start_o),
	.halt_o(halt_o), .ucode_o(ucode_o));

// ### verification/testbench.sv
`timescale 1ns/100ps

module testbench;
	import pfar_pkg::*;
	localparam int IP = 30, IR = 20, WN = 25, PD = 20;
	logic mclk_i = 0, srst_i = 1, mains = 0, brief = 0, halt_rq = 0;
	logic rst_ins = 0, svc = 0, taken = 0, pdone = 0;
	logic ac_n, dc_n, init, win, pend, trap, pstart, halt;
	pfar_ucode_s uc;
	int n_mismatch = 0, comparisons = 0, cyc = 0, n;

	// free-running clock
	initial forever #2 mclk_i = ~mclk_i;

	pfar_supply #(.GAP(8)) u_sup (.mclk_i(mclk_i), .mains_i(mains), .brief_i(brief),
		.ac_low_warning_n_o(ac_n), .dc_low_shutdown_n_o(dc_n));

	pfar_seq #(.INIT_PUP_CNT(IP), .INIT_RST_CNT(IR), .WINDOW_CNT(WN), .POWERDOWN_TIMER_CNT(PD)) DUT (
		.mclk_i(mclk_i), .srst_i(srst_i), .ac_low_warning_n_i(ac_n), .dc_low_shutdown_n_i(dc_n),
		.halt_request_i(halt_rq), .reset_instr_i(rst_ins), .service_state_i(svc),
		.trap_taken_i(taken), .pup_done_i(pdone), .init_o(init), .powerup_window_o(win),
		.power_fail_pending_o(pend), .power_fail_trap_o(trap), .powerup_start_o(pstart),
		.halt_o(halt), .ucode_o(uc));

	task chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask

	// length of next high pulse on init (w=0) or window (w=1)
	task plen(input bit w, output int k);
		k = 0;
		repeat (400) if ((w ? win : init) !== 1'b1) @(negedge mclk_i);
		while ((w ? win : init) === 1'b1 && k < 400)
		begin
			k++;
			@(negedge mclk_i);
		end
	endtask

	task summarize;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard
	always @(posedge mclk_i)
		if (++cyc == 1000)
		begin
			n_mismatch++;
			summarize;
		end

	initial
	begin
		repeat (6) @(negedge mclk_i);
		srst_i = 0;
		chk(init === 1'b0 && uc.power_init === 1'b0, "reset state");
		halt_rq = 1;
		mains = 1;
		plen(0, n);
		chk(n >= IP && n <= IP + 2, "powerup init length");
		chk(uc.power_init === 1'b1, "power init flag");
		chk(pstart === 1'b1 && uc.uaddr === 9'h001 && uc.pc_vec === 16'h0014 && uc.psw_vec === 16'h0016, "powerup start vectors");
		svc = 1;
		fork
			plen(1, n);
			begin
				brief = 1;
				repeat (6) @(negedge mclk_i);
				brief = 0;
			end
		join
		chk(n >= WN - 2 && n <= WN + 2 && pend === 1'b0, "window");
		chk(halt === 1'b0 && uc.halt_after === 1'b1, "halt before vector fetch");
		pdone = 1;
		@(negedge mclk_i);
		pdone = 0;
		chk(halt === 1'b1, "halt after vector fetch");
		halt_rq = 0;
		brief = 1;
		repeat (8) @(negedge mclk_i);
		chk(uc.power_init === 1'b0 && halt === 1'b0, "flags cleared");
		chk(pend === 1'b1 && trap === 1'b1, "power fail trap");
		taken = 1;
		@(negedge mclk_i);
		taken = 0;
		brief = 0;
		@(negedge mclk_i);
		chk(trap === 1'b0 && pend === 1'b0, "trap release");
		plen(0, n);
		chk(n >= IP && n <= IP + 2, "restart init");
		plen(1, n);
		chk(n >= WN - 2 && n <= WN + 2 && pstart === 1'b0, "restart window");
		rst_ins = 1;
		@(negedge mclk_i);
		rst_ins = 0;
		plen(0, n);
		chk(n >= IR && n <= IR + 2, "reset instr init");
		repeat (3) @(negedge mclk_i);
		chk(win === 1'b0, "no window after reset instr");
		mains = 0;
		repeat (16) @(negedge mclk_i);
		chk(init === 1'b0 && win === 1'b0, "shutdown");
		summarize;
	end
endmodule // testbench
